// ### hdl/lsm_alarm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_alarm_ctrl
(
  input  wire  logic                    i_mclk,
  input  wire  logic                    i_rst_n,
  input  wire  logic                    i_ce,
  input  wire  logic [7:0]              i_reg_addr,
  input  wire  logic                    i_reg_wr,
  input  wire  logic                    i_reg_rd,
  input  wire  logic [7:0]              i_reg_wdata,
  output logic [7:0]                    o_reg_rdata,
  input  wire  lsm_pkg::lsm_mode_t      i_mode,
  input  wire  logic [7:0]              i_chan_disable,
  input  wire  lsm_pkg::lsm_alarm_evt_t i_evt,
  output logic                          o_monitor_run,
  output logic                          o_int_out,
  output logic                          o_int_oe,
  output logic                          o_int_n
);
  import lsm_pkg::*;

  // Register state and its next values
  logic [7:0] config_q;
  logic [7:0] next_config;
  logic [7:0] status_q;
  logic [7:0] next_status;
  logic [7:0] mask_q;
  logic [7:0] next_mask;
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  logic       int_oe_q;
  logic       next_int_oe;
  // Decoded strobes and views of the register state
  logic [7:0] valid;
  logic [7:0] set_evt;
  logic       wr_cfg;
  logic       wr_mask;
  logic       do_init;
  logic       run;
  logic       pending;
  lsm_cfg_t   cfg;

  // Control bits that read back; init and reserved bits read as zero
  localparam logic [7:0] CFG_RD_MASK = (8'h01 << LSM_CFG_START_BIT) |
                                       (8'h01 << LSM_CFG_INTEN_BIT) |
                                       (8'h01 << LSM_CFG_ICLR_BIT);

  // Every field must fit the byte; a stray one would silently vanish
  if (LSM_CFG_START_BIT > 7 || LSM_CFG_INTEN_BIT > 7 ||
      LSM_CFG_ICLR_BIT > 7 || LSM_CFG_INIT_BIT > 7 ||
      LSM_TEMP_BIT > 7)
  begin : g_field_check
    $error("lsm_alarm_ctrl control field lies outside the byte");
  end

  // Decoded control bits
  // int_clear doubles as the loop stop, so it gates events and pin
  assign cfg.start     = config_q[LSM_CFG_START_BIT];
  assign cfg.int_en    = config_q[LSM_CFG_INTEN_BIT];
  assign cfg.int_clear = config_q[LSM_CFG_ICLR_BIT];

  // Write decode; the status offset has no write path at all
  // Writes to unmapped offsets fall through and change nothing
  assign wr_cfg  = i_reg_wr && (i_reg_addr == LSM_OFS_CONFIG);
  assign wr_mask = i_reg_wr && (i_reg_addr == LSM_OFS_MASK);
  // Init acts as a strobe and is never stored, so it self-clears
  assign do_init = wr_cfg && i_reg_wdata[LSM_CFG_INIT_BIT];

  // Monitoring runs only when started and not held by interrupt clear
  // Events that arrive while stopped are dropped, not queued
  assign run = cfg.start & ~cfg.int_clear;

  // Per-mode slot layout and event qualification live apart
  lsm_bit_map
  #(
    .WIDTH          (8)
  )
  u_map
  (
    .i_mode         (i_mode),
    .i_evt          (i_evt),
    .i_chan_disable (i_chan_disable),
    .i_run          (run),
    .o_valid        (valid),
    .o_set          (set_evt)
  );

  // Control register; init loads defaults so its own bit never sticks
  // Only implemented bits are kept; reserved ones stay zero
  always_comb
  begin
    next_config = config_q;
    if (do_init)
    begin
      next_config = LSM_CONFIG_RST;
    end
    else if (wr_cfg)
    begin
      next_config = 8'h00;
      next_config[LSM_CFG_START_BIT] = i_reg_wdata[LSM_CFG_START_BIT];
      next_config[LSM_CFG_INTEN_BIT] = i_reg_wdata[LSM_CFG_INTEN_BIT];
      next_config[LSM_CFG_ICLR_BIT]  = i_reg_wdata[LSM_CFG_ICLR_BIT];
    end
  end

  // i_ce low freezes every register here, the pin drive included
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      config_q <= LSM_CONFIG_RST;
    else if (i_ce)
      config_q <= next_config;
  end

  // Sticky alarm bits; an event in the init cycle still lands
  // Slots outside the current layout drop out at every update, so a
  // mode change hides them and later forgets them
  always_comb
  begin
    next_status = status_q;
    if (do_init)
      next_status = LSM_STATUS_RST;
    // Set wins over init so no alarm is lost across the clear
    next_status = (next_status | set_evt) & valid;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status_q <= LSM_STATUS_RST;
    else if (i_ce)
      status_q <= next_status;
  end

  // Mask register; reserved positions are dropped on write
  // A masked alarm still shows in status; only the pin ignores it
  always_comb
  begin
    next_mask = mask_q;
    if (do_init)
      next_mask = LSM_MASK_RST;
    else if (wr_mask)
      next_mask = i_reg_wdata & valid;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      mask_q <= LSM_MASK_RST;
    else if (i_ce)
      mask_q <= next_mask;
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  // A read in the cycle of a write to the same offset sees the old value
  // Read data holds between reads, so it may be sampled late
  always_comb
  begin
    next_rdata = rdata_q;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        LSM_OFS_CONFIG: next_rdata = config_q & CFG_RD_MASK;
        LSM_OFS_STATUS: next_rdata = status_q & valid;
        LSM_OFS_MASK:   next_rdata = mask_q & valid;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= 8'h00;
    else if (i_ce)
      rdata_q <= next_rdata;
  end

  // Any unmasked alarm asks for the pin
  // Reserved slots are cut again in case the mode has just changed
  assign pending = |(status_q & ~mask_q & valid);

  // Pin drive is registered so the pad never glitches on decode
  // Cost: the pin follows a new alarm one clock late
  // It is held low only by the gated request, never by a raw bit
  always_comb
  begin
    next_int_oe = pending & cfg.int_en & ~cfg.int_clear;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      int_oe_q <= 1'b0;
    else if (i_ce)
      int_oe_q <= next_int_oe;
  end

  // Open-drain style: only ever pulls low, released otherwise
  // The line is never driven high; the board pull-up does that
  assign o_int_out     = 1'b0;
  assign o_int_oe      = int_oe_q;
  assign o_int_n       = ~int_oe_q;

  // Register side views
  assign o_reg_rdata   = rdata_q;
  assign o_monitor_run = run;

endmodule
`default_nettype wire

// ### hdl/lsm_bit_map.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_bit_map
#(
  parameter int WIDTH = 8
)
(
  input  wire  lsm_pkg::lsm_mode_t      i_mode,
  input  wire  lsm_pkg::lsm_alarm_evt_t i_evt,
  input  wire  logic [WIDTH-1:0]        i_chan_disable,
  input  wire  logic                    i_run,
  output logic [WIDTH-1:0]              o_valid,
  output logic [WIDTH-1:0]              o_set
);
  import lsm_pkg::*;

  // The layout is fixed at one byte; wider maps have no meaning
  if (WIDTH != 8)
  begin : g_width_check
    $error("lsm_bit_map supports WIDTH of 8 only");
  end

  // Implemented slots for the current mode; reserved slots never set
  always_comb
  begin
    case (i_mode)
      LSM_MODE_SINGLE:  o_valid = LSM_VALID_M0;
      LSM_MODE_SINGLE8: o_valid = LSM_VALID_M1;
      LSM_MODE_DIFF:    o_valid = LSM_VALID_M2;
      LSM_MODE_MIXED:   o_valid = LSM_VALID_M3;
      default:          o_valid = LSM_VALID_M0;
    endcase
  end

  // Per slot set condition; temperature slot only trips on its high limit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_slot
      logic temp_only;
      assign temp_only = (g == LSM_TEMP_BIT) &&
                         (i_mode != LSM_MODE_SINGLE8);
      // Disabled channels and a stopped loop raise nothing
      assign o_set[g] = i_run & o_valid[g] & ~i_chan_disable[g] &
                        (i_evt.above_high[g] |
                         (i_evt.below_low[g] & ~temp_only));
    end
  endgenerate

endmodule
`default_nettype wire

// ### hdl/lsm_pkg.sv
`default_nettype none
package lsm_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] LSM_OFS_CONFIG = 8'h00;
  localparam logic [7:0] LSM_OFS_STATUS = 8'h01;
  localparam logic [7:0] LSM_OFS_MASK   = 8'h03;

  // Control register field positions
  localparam int LSM_CFG_START_BIT = 0;
  localparam int LSM_CFG_INTEN_BIT = 1;
  localparam int LSM_CFG_ICLR_BIT  = 3;
  localparam int LSM_CFG_INIT_BIT  = 7;

  // Values after reset or initialization
  localparam logic [7:0] LSM_CONFIG_RST = 8'h08;
  localparam logic [7:0] LSM_STATUS_RST = 8'h00;
  localparam logic [7:0] LSM_MASK_RST   = 8'h00;

  // Implemented bits of status and mask per input mode
  localparam logic [7:0] LSM_VALID_M0 = 8'hff;
  localparam logic [7:0] LSM_VALID_M1 = 8'hff;
  localparam logic [7:0] LSM_VALID_M2 = 8'h8f;
  localparam logic [7:0] LSM_VALID_M3 = 8'hbf;

  // Slot that carries the temperature alarm outside mode 1
  localparam int LSM_TEMP_BIT = 7;

  typedef enum logic [1:0] {
    LSM_MODE_SINGLE = 2'h0,
    LSM_MODE_SINGLE8 = 2'h1,
    LSM_MODE_DIFF   = 2'h2,
    LSM_MODE_MIXED  = 2'h3
  } lsm_mode_t;

  // Comparator events, one bit per status slot, one-cycle pulses
  typedef struct packed {
    logic [7:0] above_high;
    logic [7:0] below_low;
  } lsm_alarm_evt_t;

  // Decoded control register bits
  typedef struct packed {
    logic start;
    logic int_en;
    logic int_clear;
  } lsm_cfg_t;

endpackage
`default_nettype wire

// ### verification/lsm_alarm_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_alarm_ctrl_monitor
  import lsm_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire lsm_mode_t  i_mode,
  input wire logic       o_monitor_run,
  input wire logic       o_int_out,
  input wire logic       o_int_oe,
  input wire logic       o_int_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic cfg_wr;
  logic rd_any;
  // Control writes and reads of any offset seen by the register port
  assign cfg_wr = i_ce && i_reg_wr && i_reg_addr == 8'h00;
  assign rd_any = i_ce && i_reg_rd;
  a_en_off_pin: assert property (
    cfg_wr && !i_reg_wdata[1] ##1 i_ce |=> !o_int_oe) else $error("pin on");
  a_clear_pin: assert property (
    cfg_wr && i_reg_wdata[3] ##1 i_ce |=> !o_int_oe) else $error("pin held");
  a_clear_stop: assert property (
    cfg_wr && i_reg_wdata[3] |=> !o_monitor_run) else $error("loop runs");
  a_init_mask: assert property (
    cfg_wr && i_reg_wdata[7] ##1 !i_reg_wr ##1 (rd_any && i_reg_addr == 8'h03)
    |=> o_reg_rdata == 8'h00) else $error("mask kept");
  a_diff_resv: assert property (
    rd_any && i_reg_addr[7:2] == 6'h00 && i_reg_addr[0] &&
    i_mode == LSM_MODE_DIFF |=> o_reg_rdata[6:4] == 3'h0)
    else $error("reserved set");
  a_unmapped_zero: assert property (
    rd_any && i_reg_addr == 8'h02 |=> o_reg_rdata == 8'h00)
    else $error("unmapped data");
  a_pin_polarity: assert property (
    o_int_n == !o_int_oe && !o_int_out) else $error("pin polarity");
  a_mask_all: assert property (
    i_ce && i_reg_wr && i_reg_addr == 8'h03 && i_reg_wdata == 8'hff &&
    !i_mode[1] ##1 i_ce |=> !o_int_oe) else $error("masked pin on");
endmodule
bind lsm_alarm_ctrl lsm_alarm_ctrl_monitor u_lsm_alarm_ctrl_monitor
(
  .i_mclk        (i_mclk),
  .i_rst_n       (i_rst_n),
  .i_ce          (i_ce),
  .i_reg_addr    (i_reg_addr),
  .i_reg_wr      (i_reg_wr),
  .i_reg_rd      (i_reg_rd),
  .i_reg_wdata   (i_reg_wdata),
  .o_reg_rdata   (o_reg_rdata),
  .i_mode        (i_mode),
  .o_monitor_run (o_monitor_run),
  .o_int_out     (o_int_out),
  .o_int_oe      (o_int_oe),
  .o_int_n       (o_int_n)
);
`default_nettype wire

// ### verification/lsm_alarm_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_alarm_ctrl_tb_top;
  import lsm_pkg::*;
  logic           i_mclk = 1'b0;
  logic           i_rst_n = 1'b0;
  logic           i_ce = 1'b1;
  logic           i_reg_wr = 1'b0;
  logic           i_reg_rd = 1'b0;
  logic [7:0]     i_reg_addr = 8'h00;
  logic [7:0]     i_reg_wdata = 8'h00;
  logic [7:0]     i_chan_disable = 8'h00;
  lsm_mode_t      i_mode = LSM_MODE_SINGLE;
  lsm_alarm_evt_t i_evt = '0;
  logic [7:0]     o_reg_rdata, v, st, r;
  logic           o_monitor_run, o_int_out, o_int_oe, o_int_n, pin;
  logic [2:0]     s;
  int             errors = 0, compares = 0, cyc = 0, seed = 77;
  // Clock enable drops once per mode to show that state freezes
  always #25 i_mclk = ~i_mclk;
  lsm_alarm_ctrl u_lsm_alarm_ctrl
  (
    .i_mclk         (i_mclk),
    .i_rst_n        (i_rst_n),
    .i_ce           (i_ce),
    .i_reg_addr     (i_reg_addr),
    .i_reg_wr       (i_reg_wr),
    .i_reg_rd       (i_reg_rd),
    .i_reg_wdata    (i_reg_wdata),
    .o_reg_rdata    (o_reg_rdata),
    .i_mode         (i_mode),
    .i_chan_disable (i_chan_disable),
    .i_evt          (i_evt),
    .o_monitor_run  (o_monitor_run),
    .o_int_out      (o_int_out),
    .o_int_oe       (o_int_oe),
    .o_int_n        (o_int_n)
  );
  lsm_host_model u_lsm_host_model (.i_int_oe(o_int_oe),
    .i_int_out(o_int_out), .o_pin(pin));
  task automatic final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got bit %b want %b", $time, g, e);
    end
  endtask
  // Strobes rise and fall on falling edges, one cycle wide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    chk(o_reg_rdata, e);
  endtask
  task automatic ev(input logic [7:0] h, input logic [7:0] l);
    @(negedge i_mclk);
    i_evt = {h, l};
    @(negedge i_mclk);
    i_evt = '0;
  endtask
  function automatic logic [7:0] valid(input lsm_mode_t m);
    return m == LSM_MODE_DIFF ? LSM_VALID_M2 :
           m == LSM_MODE_MIXED ? LSM_VALID_M3 :
           m == LSM_MODE_SINGLE8 ? LSM_VALID_M1 : LSM_VALID_M0;
  endfunction
  // A hang ends the run as a failure
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      final_report;
    end
  end
  initial
  begin
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h02, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      i_mode = lsm_mode_t'(m);
      v = valid(i_mode);
      st = (m == 1) ? 8'h80 : 8'h00;
      wr(8'h00, 8'h80);
      wr(8'h03, 8'hff);
      r = 8'($random(seed));
      wr(8'h03, r);
      rd(8'h03, r & v);
      wr(8'h01, 8'hff);
      rd(8'h01, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h00, 8'h03);
      do s = 3'($random(seed)); while (!v[s]);
      i_chan_disable = 8'h01 << s;
      ev(8'h01 << s, 8'h00);
      i_chan_disable = 8'h00;
      ev(8'h00, 8'h80);
      rd(8'h01, st);
      ev(8'h01 << s, 8'h00);
      st = st | (8'h01 << s);
      rd(8'h01, st);
      chk_bit(pin, 1'b0);
      chk_bit(o_int_n, 1'b0);
      chk_bit(o_monitor_run, 1'b1);
      wr(8'h00, 8'h01);
      rd(8'h01, st);
      chk_bit(pin, 1'b1);
      wr(8'h00, 8'h03);
      wr(8'h03, st);
      rd(8'h03, st);
      chk_bit(pin, 1'b1);
      wr(8'h00, 8'h0b);
      wr(8'h03, 8'h00);
      rd(8'h01, st);
      chk_bit(pin, 1'b1);
      chk_bit(o_monitor_run, 1'b0);
      // A frozen clock enable must swallow the init write
      i_ce = 1'b0;
      wr(8'h00, 8'h80);
      i_ce = 1'b1;
      rd(8'h01, st);
      wr(8'h00, 8'h80);
      rd(8'h03, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h00, 8'h08);
    end
    // Reset in mid-run with an alarm holding the pin low
    wr(8'h00, 8'h03);
    ev(8'h01, 8'h00);
    rd(8'h01, 8'h01);
    chk_bit(pin, 1'b0);
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    chk_bit(pin, 1'b1);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h08);
    chk_bit(o_monitor_run, 1'b0);
    final_report;
  end
endmodule
`default_nettype wire

// ### verification/lsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_host_model
(
  input  wire logic i_int_oe,
  input  wire logic i_int_out,
  output logic      o_pin
);
  // Pull-up holds the line high whenever the device lets go of it
  assign o_pin = i_int_oe ? i_int_out : 1'b1;
endmodule
`default_nettype wire
